// ===== hw/gia_aggregator.sv
`timescale 1ns/1ps
`default_nettype none
module gia_aggregator #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Channel source events, one bit per channel
	input wire logic [3:0] rx_data_ready_set,
	input wire logic [3:0] line_status_set,
	input wire logic [3:0] rx_timeout_set,
	input wire logic [3:0] tx_space_ready_set,
	input wire logic [3:0] modem_set,
	input wire logic [3:0] flow_special_set,
	// Channel clearing reads, one bit per channel
	input wire logic [3:0] rx_buffer_read,
	input wire logic [3:0] line_status_read,
	input wire logic [3:0] irq_status_read,
	input wire logic [3:0] modem_status_read,
	// Device wide sources and their clearing reads
	input wire logic timer_timeout,
	input wire logic pin_event,
	input wire logic timer_cmd_read,
	input wire logic pin_level_read,
	input wire logic [3:0] sleep_mode,
	// Condensed request
	output logic irq_any
);
	logic [3:0] chan_pending;
	logic [2:0] chan_code [4];
	logic [2:0] code0;
	logic [3:0] summary;
	logic [31:0] word;
	logic timer_q, pin_q, wake_q;
	logic summary_read;
	logic hit_word, hit_ctrl;
	logic [31:0] ctrl_q;
	logic [31:0] rdata_q;
	logic irq_q;

	// Address decode
	assign hit_word = reg_addr == ADDR_W'(gia_pkg::GLOBAL_WORD_OFFSET);
	assign hit_ctrl = reg_addr == ADDR_W'(gia_pkg::AGG_CTRL_OFFSET);
	// Any read of the word covers its summary byte
	assign summary_read = reg_rd & hit_word;

	// One flag set per channel
	for (genvar i = 0; i < gia_pkg::NUM_CHAN; i++) begin : g_chan
		gia_chan_flags u_flags (
			.clk(clk),
			.rst(rst),
			.rx_data_ready_set(rx_data_ready_set[i]),
			.line_status_set(line_status_set[i]),
			.rx_timeout_set(rx_timeout_set[i]),
			.tx_space_ready_set(tx_space_ready_set[i]),
			.modem_set(modem_set[i]),
			.flow_special_set(flow_special_set[i]),
			.rx_buffer_read(rx_buffer_read[i]),
			.line_status_read(line_status_read[i]),
			.irq_status_read(irq_status_read[i]),
			.modem_status_read(modem_status_read[i]),
			.pending(chan_pending[i]),
			.code(chan_code[i])
		);
	end

	// Device wide flags, all tied to channel 0
	gia_global_flags u_global (
		.clk(clk),
		.rst(rst),
		.timer_timeout(timer_timeout),
		.pin_event(pin_event),
		.sleep_mode(sleep_mode),
		.wake_en(ctrl_q[gia_pkg::WAKE_EN_BIT]),
		.timer_cmd_read(timer_cmd_read),
		.pin_level_read(pin_level_read),
		.summary_read(summary_read),
		.timer_q(timer_q),
		.pin_q(pin_q),
		.wake_q(wake_q)
	);

	// Channel 0 code, channel sources ahead of device wide ones
	always_comb begin
		if (chan_pending[0]) begin
			code0 = chan_code[0];
		end else if (pin_q) begin
			code0 = gia_pkg::CODE_PIN;
		end else if (timer_q) begin
			code0 = gia_pkg::CODE_TIMER;
		end else begin
			code0 = gia_pkg::CODE_NONE;
		end
	end

	// Summary bits follow any pending source
	always_comb begin
		summary = chan_pending;
		summary[0] = chan_pending[0] | pin_q | timer_q | wake_q;
	end

	// Interrupt word assembly
	always_comb begin
		word = gia_pkg::GLOBAL_WORD_RESET;
		word[gia_pkg::SUMMARY_LSB +: 4] = summary;
		word[gia_pkg::CODE_LSB +: gia_pkg::CODE_W] = code0;
		for (int c = 1; c < gia_pkg::NUM_CHAN; c++) begin
			word[gia_pkg::CODE_LSB + c * gia_pkg::CODE_W +: gia_pkg::CODE_W]
				= chan_code[c];
		end
	end

	// Control register write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= gia_pkg::AGG_CTRL_RESET;
		end else if (reg_wr && hit_ctrl) begin
			ctrl_q <= {31'h0000_0000, reg_wdata[gia_pkg::WAKE_EN_BIT]};
		end
	end

	// Read data, valid the cycle after the strobe only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= gia_pkg::UNMAPPED_READ;
		end else if (reg_rd && hit_word) begin
			rdata_q <= word;
		end else if (reg_rd && hit_ctrl) begin
			rdata_q <= ctrl_q;
		end else begin
			rdata_q <= gia_pkg::UNMAPPED_READ;
		end
	end
	assign reg_rdata = rdata_q;

	// Registered request summary
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |summary;
		end
	end
	assign irq_any = irq_q;

	reserved_bits_a: assert property (@(posedge clk) disable iff (rst)
		rdata_q[7:4] == 4'h0 && rdata_q[31:20] == 12'h000)
		else $error("reserved bits of the word read nonzero");
	summary_agree_a: assert property (@(posedge clk) disable iff (rst)
		(word[1] == (word[13:11] != 3'h0)) && (word[3] == (word[19:17] != 3'h0))
		&& (word[0] == ((word[10:8] != 3'h0) || wake_q)))
		else $error("summary bit disagrees with its code");
	// Codes 6 and 7 have their two upper bits set; modem code 4 does not
	global_ch0_only_a: assert property (@(posedge clk) disable iff (rst)
		word[13:12] != 2'b11 && word[16:15] != 2'b11
		&& word[19:18] != 2'b11)
		else $error("device wide code outside channel 0");
	uart_first_a: assert property (@(posedge clk) disable iff (rst)
		chan_pending[0] |-> word[10:8] inside {[3'h1:3'h4]})
		else $error("channel 0 source lost to a device wide one");
	word_read_a: assert property (@(posedge clk) disable iff (rst)
		reg_rd && hit_word |=> reg_rdata == $past(word))
		else $error("word read returned stale data");
	// A fresh wake event in the read cycle wins over the clear
	wake_clear_a: assert property (@(posedge clk) disable iff (rst)
		summary_read && !(u_global.all_asleep_q && !(&sleep_mode))
		|=> !wake_q)
		else $error("wake flag survived a summary read");
	wake_rise_a: assert property (@(posedge clk) disable iff (rst)
		ctrl_q[0] && &sleep_mode ##1 !(&sleep_mode) |=> wake_q)
		else $error("wake flag missed after full sleep");
	code_none_a: assert property (@(posedge clk) disable iff (rst)
		word[10:8] == 3'h0 |-> !chan_pending[0] && !pin_q && !timer_q)
		else $error("code zero with a pending channel 0 source");
	rx_first_a: assert property (@(posedge clk) disable iff (rst)
		$past(rx_data_ready_set[2]) && !$past(rx_buffer_read[2])
		|-> word[16:14] == 3'h1)
		else $error("receive source not ranked first");
	lsr_clear_a: assert property (@(posedge clk) disable iff (rst)
		line_status_read[1] && !line_status_set[1] && !rx_data_ready_set[1]
		&& !g_chan[1].u_flags.rx_q && word[13:11] == 3'h1
		|=> word[13:11] != 3'h1)
		else $error("line status flag survived its read");
	modem_clear_a: assert property (@(posedge clk) disable iff (rst)
		modem_status_read[3] && irq_status_read[3] && !modem_set[3]
		&& !flow_special_set[3] && word[19:17] == 3'h4 |=> word[19:17] != 3'h4)
		else $error("modem code survived its clearing reads");
	flow_clear_a: assert property (@(posedge clk) disable iff (rst)
		$past(irq_status_read[1]) && $past(modem_status_read[1])
		&& !$past(modem_set[1]) && !$past(flow_special_set[1])
		|-> word[13:11] != 3'h4)
		else $error("flow code survived its clearing reads");
	timer_code_a: assert property (@(posedge clk) disable iff (rst)
		timer_q && !pin_q && !chan_pending[0] |-> word[10:8] == 3'h7)
		else $error("timer not reported in channel 0");
endmodule
`default_nettype wire

// ===== hw/gia_pkg.sv
package gia_pkg;
	// Register map
	localparam logic [7:0] GLOBAL_WORD_OFFSET = 8'h80;
	localparam logic [7:0] AGG_CTRL_OFFSET = 8'ha0;
	localparam logic [31:0] GLOBAL_WORD_RESET = 32'h0000_0000;
	localparam logic [31:0] AGG_CTRL_RESET = 32'h0000_0001;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	// Field layout of the interrupt word
	localparam int NUM_CHAN = 4;
	localparam int SUMMARY_LSB = 0;
	localparam int CODE_LSB = 8;
	localparam int CODE_W = 3;
	localparam int WAKE_EN_BIT = 0;
	// Source codes, lowest number wins among the channel sources
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_RX = 3'h1;
	localparam logic [2:0] CODE_RX_TIMEOUT = 3'h2;
	localparam logic [2:0] CODE_TX = 3'h3;
	localparam logic [2:0] CODE_MODEM = 3'h4;
	localparam logic [2:0] CODE_RESERVED = 3'h5;
	localparam logic [2:0] CODE_PIN = 3'h6;
	localparam logic [2:0] CODE_TIMER = 3'h7;

	// Highest priority channel source as a 3-bit code
	function automatic logic [2:0] encode_uart(input logic rx,
		input logic rx_timeout, input logic tx, input logic modem);
		logic [2:0] code;
		code = CODE_NONE;
		if (rx) begin
			code = CODE_RX;
		end else if (rx_timeout) begin
			code = CODE_RX_TIMEOUT;
		end else if (tx) begin
			code = CODE_TX;
		end else if (modem) begin
			code = CODE_MODEM;
		end
		return code;
	endfunction
endpackage

// ===== hw/gia_chan_flags.sv
`timescale 1ns/1ps
`default_nettype none
module gia_chan_flags (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Source event pulses
	input wire logic rx_data_ready_set,
	input wire logic line_status_set,
	input wire logic rx_timeout_set,
	input wire logic tx_space_ready_set,
	input wire logic modem_set,
	input wire logic flow_special_set,
	// Clearing reads of the channel
	input wire logic rx_buffer_read,
	input wire logic line_status_read,
	input wire logic irq_status_read,
	input wire logic modem_status_read,
	// Condensed state
	output logic pending,
	output logic [2:0] code
);
	logic rx_q, lsr_q, tmo_q, tx_q, msr_q, flow_q;

	// Sticky flags, a set in the clearing cycle wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_q <= 1'b0;
			lsr_q <= 1'b0;
			tmo_q <= 1'b0;
			tx_q <= 1'b0;
			msr_q <= 1'b0;
			flow_q <= 1'b0;
		end else begin
			rx_q <= rx_data_ready_set | (rx_q & ~rx_buffer_read);
			tmo_q <= rx_timeout_set | (tmo_q & ~rx_buffer_read);
			lsr_q <= line_status_set | (lsr_q & ~line_status_read);
			tx_q <= tx_space_ready_set | (tx_q & ~irq_status_read);
			msr_q <= modem_set | (msr_q & ~modem_status_read);
			flow_q <= flow_special_set | (flow_q & ~irq_status_read);
		end
	end

	// Priority encode of the pending sources
	assign code = gia_pkg::encode_uart(rx_q | lsr_q, tmo_q, tx_q,
		msr_q | flow_q);
	assign pending = rx_q | lsr_q | tmo_q | tx_q | msr_q | flow_q;

	rx_clear_a: assert property (@(posedge clk) disable iff (rst)
		rx_buffer_read && !rx_data_ready_set && !rx_timeout_set
		|=> !rx_q && !tmo_q)
		else $error("receive flags survived a buffer read");
	tx_clear_a: assert property (@(posedge clk) disable iff (rst)
		irq_status_read && !tx_space_ready_set |=> !tx_q)
		else $error("transmit flag survived a status read");
endmodule
`default_nettype wire

// ===== hw/gia_global_flags.sv
`timescale 1ns/1ps
`default_nettype none
module gia_global_flags (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Device wide events
	input wire logic timer_timeout,
	input wire logic pin_event,
	input wire logic [3:0] sleep_mode,
	input wire logic wake_en,
	// Clearing reads
	input wire logic timer_cmd_read,
	input wire logic pin_level_read,
	input wire logic summary_read,
	// Flags
	output logic timer_q,
	output logic pin_q,
	output logic wake_q
);
	logic all_asleep_q;

	// Tracks whether every channel sits in sleep mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			all_asleep_q <= 1'b0;
		end else begin
			all_asleep_q <= &sleep_mode;
		end
	end

	// Timer and pin flags, set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			timer_q <= timer_timeout | (timer_q & ~timer_cmd_read);
			pin_q <= pin_event | (pin_q & ~pin_level_read);
		end
	end

	// Wake flag raised when a full sleep ends
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= (wake_en & all_asleep_q & ~&sleep_mode)
				| (wake_q & ~summary_read);
		end
	end

	timer_clear_a: assert property (@(posedge clk) disable iff (rst)
		timer_cmd_read && !timer_timeout |=> !timer_q)
		else $error("timer flag survived a command read");
	pin_clear_a: assert property (@(posedge clk) disable iff (rst)
		pin_level_read && !pin_event |=> !pin_q)
		else $error("pin flag survived a level read");
endmodule
`default_nettype wire

// ===== tb/gia_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gia_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One-cycle write; address and data scrambled once released
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	// One-cycle read; data caught mid-cycle after the taking edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge clk);
		d = reg_rdata;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// ===== tb/test_global_interrupt_aggregator.sv
`timescale 1ns/1ps
`default_nettype none
module test_global_interrupt_aggregator;
	localparam int cmap[6] = '{0, 1, 0, 2, 3, 2};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic reg_wr;
	logic reg_rd;
	logic irq_any;
	logic [23:0] sets = '0;
	logic [15:0] clrs = '0;
	logic [3:0] glob = '0;
	logic [3:0] sleep = '0;
	// Expected state of every flag
	logic [3:0] m_f [6] = '{default: '0};
	logic m_tmr = 1'b0;
	logic m_pin = 1'b0;
	logic m_wake = 1'b0;
	logic m_en = 1'b1;
	logic [3:0] m_sleep = '0;
	logic [31:0] seed = 32'h522e;
	logic [31:0] got;
	logic [31:0] r;
	logic [31:0] q;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;

	// Clock
	always #25 clk = ~clk;

	gia_host_model host (.clk(clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));

	gia_aggregator i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rx_data_ready_set(sets[23:20]),
		.line_status_set(sets[19:16]), .rx_timeout_set(sets[15:12]),
		.tx_space_ready_set(sets[11:8]), .modem_set(sets[7:4]),
		.flow_special_set(sets[3:0]), .rx_buffer_read(clrs[15:12]),
		.line_status_read(clrs[11:8]), .irq_status_read(clrs[7:4]),
		.modem_status_read(clrs[3:0]), .timer_timeout(glob[3]),
		.pin_event(glob[2]), .timer_cmd_read(glob[1]),
		.pin_level_read(glob[0]), .sleep_mode(sleep), .irq_any(irq_any));

	// Xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Interrupt word predicted from the flag model
	function automatic logic [31:0] exp_word();
		logic [31:0] w;
		logic [2:0] c;
		w = 32'h0;
		for (int ch = 0; ch < 4; ch++) begin
			c = (m_f[0][ch] | m_f[1][ch]) ? gia_pkg::CODE_RX :
				m_f[2][ch] ? gia_pkg::CODE_RX_TIMEOUT :
				m_f[3][ch] ? gia_pkg::CODE_TX :
				(m_f[4][ch] | m_f[5][ch]) ? gia_pkg::CODE_MODEM :
				gia_pkg::CODE_NONE;
			if (ch == 0 && c == gia_pkg::CODE_NONE)
				c = m_pin ? gia_pkg::CODE_PIN : m_tmr ? gia_pkg::CODE_TIMER : c;
			w[8 + 3 * ch +: 3] = c;
			w[ch] = (c != gia_pkg::CODE_NONE) | (ch == 0 && m_wake);
		end
		return w;
	endfunction

	// Compare and count
	task automatic cmp(input string n, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// One cycle of events; model follows set-beats-clear
	task automatic step(input logic [23:0] s, input logic [15:0] c,
		input logic [3:0] g, input logic [3:0] sl);
		logic [3:0] cs;
		sets <= s;
		clrs <= c;
		glob <= g;
		sleep <= sl;
		for (int k = 0; k < 6; k++) begin
			cs = c[15 - 4 * cmap[k] -: 4];
			m_f[k] = (m_f[k] & ~cs) | s[23 - 4 * k -: 4];
		end
		m_tmr = (m_tmr & ~g[1]) | g[3];
		m_pin = (m_pin & ~g[0]) | g[2];
		m_wake |= m_en & (m_sleep == 4'hf) & (sl != 4'hf);
		m_sleep = sl;
		@(posedge clk);
		sets <= '0;
		clrs <= '0;
		glob <= '0;
	endtask

	// Word read; the read itself clears wake-up
	task automatic check(input string n);
		logic [31:0] e;
		e = exp_word();
		host.rd(gia_pkg::GLOBAL_WORD_OFFSET, got);
		cmp(n, e, got);
		cmp("irq_any", {31'h0, |e[3:0]}, {31'h0, irq_any});
		m_wake = 1'b0;
	endtask

	// Verdict
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end

	// Test sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("reset word");
		host.wr(gia_pkg::GLOBAL_WORD_OFFSET, 32'hffff_ffff);
		check("word after write");
		host.rd(gia_pkg::AGG_CTRL_OFFSET, got);
		cmp("ctrl", gia_pkg::AGG_CTRL_RESET, got);
		host.rd(8'h44, got);
		cmp("unmapped", gia_pkg::UNMAPPED_READ, got);
		$display("test registers done");
		for (int ch = 0; ch < 4; ch++) begin
			for (int k = 0; k < 6; k++) begin
				step(24'h1 << (20 - 4 * k + ch), 16'h0, 4'h0, m_sleep);
				check("one source");
				step(24'h0, 16'h1 << (12 - 4 * cmap[k] + ch), 4'h0, m_sleep);
				check("cleared");
			end
		end
		$display("test sources done");
		step(24'h100, 16'h0, 4'hc, m_sleep);
		check("uart over global");
		step(24'h0, 16'h10, 4'h0, m_sleep);
		check("pin shown");
		step(24'h0, 16'h0, 4'h1, m_sleep);
		check("timer shown");
		step(24'h0, 16'h0, 4'h2, m_sleep);
		check("global cleared");
		$display("test global done");
		step(24'h0, 16'h0, 4'h0, 4'hf);
		step(24'h0, 16'h0, 4'h0, 4'h3);
		check("wake raised");
		check("wake cleared");
		host.wr(gia_pkg::AGG_CTRL_OFFSET, 32'h0);
		m_en = 1'b0;
		step(24'h0, 16'h0, 4'h0, 4'hf);
		step(24'h0, 16'h0, 4'h0, 4'h0);
		check("wake masked");
		host.wr(gia_pkg::AGG_CTRL_OFFSET, 32'h1);
		m_en = 1'b1;
		$display("test wake done");
		repeat (300) begin
			r = rnd();
			q = rnd();
			step(r[23:0] & q[23:0], q[15:0], r[31:28],
				q[31] ? 4'hf : q[27:24]);
			check("random word");
		end
		$display("test random done");
		results();
	end
endmodule
`default_nettype wire
